// *** rtl/nvac_defs.vh ***
`ifndef NVAC_DEFS_VH
`define NVAC_DEFS_VH
`define NVAC_ADDR_OFS 3'h0
`define NVAC_DATA_OFS 3'h1
`define NVAC_CTRL_OFS 3'h2
`define NVAC_KEY_OFS 3'h3
`define NVAC_IRQ_STAT_OFS 3'h4
`define NVAC_IRQ_MASK_OFS 3'h5
`define NVAC_EXT_OFS 3'h6
`define NVAC_BIT_PGM 7
`define NVAC_BIT_CFG 6
`define NVAC_BIT_FREE 4
`define NVAC_BIT_ABORT 3
`define NVAC_BIT_WRITE_ENABLE_BIT 2
`define NVAC_BIT_WR 1
`define NVAC_BIT_RD 0
`define NVAC_KEY_FIRST 8'h55
`define NVAC_KEY_SECOND 8'hAA
`define NVAC_CLK_HZ 25000000
`define NVAC_PWRT_MS 72
`define NVAC_PWRT_CYC ((`NVAC_CLK_HZ / 1000) * `NVAC_PWRT_MS)
`define NVAC_WRITE_US 4000
`define NVAC_WRITE_CYC ((`NVAC_CLK_HZ / 1000000) * `NVAC_WRITE_US)
`endif

// *** rtl/nvac_array.v ***
`timescale 1ns/1ns
// byte array with registered read port
module nvac_array (
  input wire clk,            // system clock
  input wire [7:0] raddr,    // read address
  output reg [7:0] rdata,    // registered read data
  input wire we,             // write strobe
  input wire [7:0] waddr,    // write address
  input wire [7:0] wdata     // write data
);
  reg [7:0] mem [0:255];

  // no reset: contents are nonvolatile in intent
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // nvac_array

// *** rtl/nvac_timer.v ***
`timescale 1ns/1ns
// loadable down counter, done pulse on expiry
module nvac_timer #(
  parameter [31:0] COUNT = 32'h0000_0001
) (
  input wire clk,            // system clock
  input wire reset_n,        // async reset, active low
  input wire start,          // load and run
  output wire busy,          // counting
  output reg done            // one-cycle expiry pulse
);
  reg [31:0] cnt_q;

  assign busy = (cnt_q != 32'h0);

  // count down, pulse on the step from one to zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 32'h0;
      done <= 1'b0;
    end else begin
      done <= (cnt_q == 32'h1);
      if (start) begin
        cnt_q <= COUNT;
      end else if (cnt_q != 32'h0) begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end
endmodule // nvac_timer

// *** rtl/nvac_ctrl.v ***
`timescale 1ns/1ns
`include "nvac_defs.vh"
// data array access control: key unlock, timed write, read, irq
module nvac_ctrl #(
  parameter [31:0] PWRT_CYCLES = `NVAC_PWRT_CYC,
  parameter [31:0] WRITE_CYCLES = `NVAC_WRITE_CYC
) (
  input wire clk,            // system clock
  input wire reset_n,        // async reset, active low
  input wire [2:0] addr,     // register address
  input wire [7:0] wdata,    // write data
  input wire wr_stb,         // write strobe
  input wire rd_stb,         // read strobe
  output reg [7:0] rdata,    // read data, cycle after strobe
  input wire cp_read,        // code protect against external read
  input wire cp_write,       // code protect against external write
  input wire ext_rd,         // external programmer read request
  input wire ext_wr,         // external programmer write request
  input wire [7:0] ext_addr, // external programmer address
  input wire [7:0] ext_wdata,// external programmer data
  output reg [7:0] ext_rdata,// external read data
  output reg ext_refused,    // external access refused pulse
  output wire wake,          // completion wake event, level
  output wire irq            // interrupt, level
);
  ////////////////////////////////////////////////////////////////
  // state
  localparam [1:0] KEY_IDLE = 2'h0;
  localparam [1:0] KEY_ONE = 2'h1;
  localparam [1:0] KEY_TWO = 2'h2;

  reg [7:0] nv_address_reg_q;
  reg [7:0] nv_data_reg_q;
  reg program_space_select_q;
  reg config_space_select_q;
  reg free_q;
  reg write_abort_flag_q;
  reg write_enable_bit_q;
  reg wr_busy_q;
  reg rd_pend_q;
  reg [1:0] key_q;
  reg [1:0] key_d;
  reg [1:0] stat_q;          // bit0 write done, bit1 refused
  reg [1:0] mask_q;
  reg ext_rd_pend_q;
  reg [31:0] pwrt_q;
  reg pwrt_armed_q;

  wire tmr_busy;
  wire tmr_done;
  wire [7:0] arr_rdata;
  wire sel_write;
  wire sel_ctrl;
  wire wr_go;
  wire ext_ok_rd;
  wire ext_ok_wr;
  wire arr_we;
  wire [7:0] arr_waddr;
  wire [7:0] arr_wdata;
  wire [7:0] arr_raddr;

  ////////////////////////////////////////////////////////////////
  // helpers
  function hit;
    input [2:0] a;
    input [2:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign sel_write = wr_stb;
  assign sel_ctrl = sel_write && hit(addr, `NVAC_CTRL_OFS);

  // start only from unlocked key state, prior enable, data space
  assign wr_go = sel_ctrl && wdata[`NVAC_BIT_WR] && !wr_busy_q &&
                 (key_q == KEY_TWO) && write_enable_bit_q &&
                 !program_space_select_q && !config_space_select_q &&
                 (pwrt_q == 32'h0);

  // code protect gates only the external port
  assign ext_ok_rd = ext_rd && !cp_read && !cp_write;
  assign ext_ok_wr = ext_wr && !cp_read && !cp_write && !wr_busy_q
                     && (pwrt_q == 32'h0);

  // internal timed write has precedence over external write
  assign arr_we = tmr_done || (ext_ok_wr && !tmr_busy);
  assign arr_waddr = tmr_done ? nv_address_reg_q : ext_addr;
  assign arr_wdata = tmr_done ? nv_data_reg_q : ext_wdata;
  assign arr_raddr = ext_ok_rd ? ext_addr : nv_address_reg_q;

  assign wake = stat_q[0];
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////
  // submodules
  nvac_timer #(.COUNT(WRITE_CYCLES)) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(wr_go),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  nvac_array u_array (
    .clk(clk),
    .raddr(arr_raddr),
    .rdata(arr_rdata),
    .we(arr_we),
    .waddr(arr_waddr),
    .wdata(arr_wdata)
  );

  ////////////////////////////////////////////////////////////////
  // key sequencer: any other write to the key port or to any other register drops it
  always @* begin
    key_d = key_q;
    if (sel_write && hit(addr, `NVAC_KEY_OFS)) begin
      case (key_q)
        KEY_IDLE: key_d = (wdata == `NVAC_KEY_FIRST) ? KEY_ONE
                                                      : KEY_IDLE;
        KEY_ONE: key_d = (wdata == `NVAC_KEY_SECOND) ? KEY_TWO
                                                      : KEY_IDLE;
        KEY_TWO: key_d = (wdata == `NVAC_KEY_FIRST) ? KEY_ONE
                                                     : KEY_IDLE;
        default: key_d = KEY_IDLE;
      endcase
    end else if (sel_write) begin
      key_d = KEY_IDLE;
    end
  end

  // key state, power-up timer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_q <= KEY_IDLE;
      pwrt_q <= 32'h0;
    end else begin
      key_q <= key_d;
      // load once on the first edge after release, then run down
      if (!pwrt_armed_q) begin
        pwrt_q <= PWRT_CYCLES;
      end else if (pwrt_q != 32'h0) begin
        pwrt_q <= pwrt_q - 32'h1;
      end
    end
  end

  // power-up hold: marks that the hold timer has been loaded
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwrt_armed_q <= 1'b0;
    end else begin
      pwrt_armed_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control and data registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_address_reg_q <= 8'h00;
      nv_data_reg_q <= 8'h00;
      write_enable_bit_q <= 1'b0;
      free_q <= 1'b0;
      program_space_select_q <= 1'b0;
      config_space_select_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_busy_q <= 1'b0;
    end else begin
      rd_pend_q <= 1'b0;
      if (wr_go) begin
        wr_busy_q <= 1'b1;
      end else if (tmr_done) begin
        wr_busy_q <= 1'b0;
      end
      // frozen while the write runs
      if (sel_write && !wr_busy_q) begin
        if (hit(addr, `NVAC_ADDR_OFS)) begin
          nv_address_reg_q <= wdata;
        end
        if (hit(addr, `NVAC_DATA_OFS)) begin
          nv_data_reg_q <= wdata;
        end
        if (sel_ctrl) begin
          program_space_select_q <= wdata[`NVAC_BIT_PGM];
          config_space_select_q <= wdata[`NVAC_BIT_CFG];
          free_q <= wdata[`NVAC_BIT_FREE];
          // only an explicit write ever clears enable
          write_enable_bit_q <= wdata[`NVAC_BIT_WRITE_ENABLE_BIT];
          if (wdata[`NVAC_BIT_RD] && !wdata[`NVAC_BIT_PGM] &&
              !program_space_select_q) begin
            rd_pend_q <= 1'b1;
          end
        end
      end
      // array data lands one cycle after the read start
      if (rd_pend_q) begin
        nv_data_reg_q <= arr_rdata;
      end
    end
  end

  // abort flag: set at write start and cleared on completion, so it follows busy;
  // reset clears it and the per-cycle busy copy, so a reset mid-write is not seen
  reg busy_at_reset_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_abort_flag_q <= 1'b0;
      busy_at_reset_q <= 1'b0;
    end else begin
      busy_at_reset_q <= wr_busy_q;
      if (wr_go) begin
        write_abort_flag_q <= 1'b1;
      end else if (tmr_done) begin
        write_abort_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupt status: set wins over read clear
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= 2'h0;
      mask_q <= 2'h0;
    end else begin
      if (rd_stb && hit(addr, `NVAC_IRQ_STAT_OFS)) begin
        stat_q <= {ext_refused, tmr_done};
      end else begin
        stat_q <= stat_q | {ext_refused, tmr_done};
      end
      if (sel_write && hit(addr, `NVAC_IRQ_MASK_OFS)) begin
        mask_q <= wdata[1:0];
      end
    end
  end

  // external port answers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_rdata <= 8'h00;
      ext_refused <= 1'b0;
      ext_rd_pend_q <= 1'b0;
    end else begin
      ext_rd_pend_q <= ext_ok_rd;
      ext_refused <= (ext_rd && !ext_ok_rd) ||
                     (ext_wr && !ext_ok_wr);
      if (ext_rd_pend_q) begin
        ext_rdata <= arr_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // read mux; key port reads zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `NVAC_ADDR_OFS: rdata <= nv_address_reg_q;
        `NVAC_DATA_OFS: rdata <= nv_data_reg_q;
        `NVAC_CTRL_OFS: rdata <= {program_space_select_q,
                                  config_space_select_q, 1'b0, free_q,
                                  write_abort_flag_q,
                                  write_enable_bit_q, wr_busy_q,
                                  rd_pend_q};
        `NVAC_KEY_OFS: rdata <= 8'h00;
        `NVAC_IRQ_STAT_OFS: rdata <= {6'h00, stat_q};
        `NVAC_IRQ_MASK_OFS: rdata <= {6'h00, mask_q};
        `NVAC_EXT_OFS: rdata <= {6'h00, cp_write, cp_read};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // nvac_ctrl

// *** dv/nvac_asserts.sv ***
`timescale 1ns/1ns
// port-level checks on the access controller
module nvac_asserts (
  input wire clk, // system clock
  input wire reset_n, // async reset, active low
  input wire [2:0] addr, // register index
  input wire [7:0] wdata, // write data
  input wire wr_stb, // write strobe
  input wire rd_stb, // read strobe
  input wire [7:0] rdata, // read data
  input wire cp_read, // read protect
  input wire cp_write, // write protect
  input wire ext_rd, // external read
  input wire ext_wr, // external write
  input wire ext_refused, // external refusal pulse
  input wire wake, // done level
  input wire irq // interrupt level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////
  // read port: data only in the cycle after a strobe
  a_rdata_idle: assert property (
    !$past(rd_stb) |-> rdata == 8'h00) else $error("rdata not idle");
  a_key_reads_zero: assert property (
    rd_stb && addr == 3'h3 |=> rdata == 8'h00) else $error("key port read");
  // either protect setting blocks the programmer, none does not
  a_ext_refused: assert property (
    (ext_rd || ext_wr) && (cp_read || cp_write) |=> ext_refused)
    else $error("protected access not refused");
  a_refuse_cause: assert property (
    ext_refused |-> $past((ext_rd || ext_wr) && (cp_read || cp_write)))
    else $error("refusal without cause");
  a_free_ext_ok: assert property (
    (ext_rd || ext_wr) && !cp_read && !cp_write |=> !ext_refused)
    else $error("free access refused");
  // done event is sticky until the status read takes it
  a_wake_sticky: assert property (
    wake && !(rd_stb && addr == 3'h4) |=> wake) else $error("wake dropped");
  a_wake_clear: assert property (
    rd_stb && addr == 3'h4 |=> !wake) else $error("wake kept after read");
  a_mask_off_irq: assert property (
    wr_stb && addr == 3'h5 && wdata == 8'h00 |=> !irq)
    else $error("irq with mask clear");
endmodule // nvac_asserts

// *** dv/tb_data_eeprom_access_control.sv ***
`timescale 1ns/1ns
// self-checking bench for the data array access controller
module tb_data_eeprom_access_control;
  logic clk, reset_n, wr_stb, rd_stb, cp_read, cp_write, ext_rd, ext_wr;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, ext_addr, ext_wdata, ext_rdata, a0, d0;
  logic ext_refused, wake, irq, rd_q, e1, e2, e3;
  logic [7:0] exp_q[$], msk_q[$], ext_q[$];
  int bad_count, compares, cyc, n, i;
  // short write time keeps the run brief
  nvac_ctrl #(.PWRT_CYCLES(32'h0), .WRITE_CYCLES(32'h8)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cp_read(cp_read),
    .cp_write(cp_write), .ext_rd(ext_rd), .ext_wr(ext_wr),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .ext_refused(ext_refused), .wake(wake), .irq(irq));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // masked compare, an unknown in a checked bit counts as bad
  task chk(input string nm, input logic [7:0] e, g, m);
    compares++;
    if (((g ^ e) & m) !== 8'h00) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr_stb <= 1'h1; rd_stb <= 1'h0;
    @(posedge clk);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e, m);
    addr <= a; rd_stb <= 1'h1; wr_stb <= 1'h0;
    exp_q.push_back(e); msk_q.push_back(m);
    @(posedge clk);
  endtask
  task idle(input int c);
    wr_stb <= 1'h0; rd_stb <= 1'h0;
    repeat (c) @(posedge clk);
  endtask
  task unlock;
    wr(3'h3, 8'h55); wr(3'h3, 8'hAA);
  endtask
  task wait_done;
    idle(1);
    for (n = 0; n < 40 && wake !== 1'h1; n++) @(posedge clk);
    chk("wake", 8'h01, {7'h00, wake}, 8'h01);
  endtask
  task ext(input logic r, w);
    ext_rd <= r; ext_wr <= w; ext_addr <= a0; ext_wdata <= ~d0;
    @(posedge clk);
    ext_rd <= 1'h0; ext_wr <= 1'h0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////
  // watcher: oldest note against each result as it appears
  always @(posedge clk) begin
    rd_q <= rd_stb;
    e1 <= ext_rd & ~cp_read & ~cp_write;
    e2 <= e1;
    e3 <= e2;
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop;
    end
  end
  always @(negedge clk) begin
    if (rd_q === 1'h1) chk("rdata", exp_q.pop_front(), rdata, msk_q.pop_front());
    if (e3 === 1'h1) chk("ext_rdata", ext_q.pop_front(), ext_rdata, 8'hFF);
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, wr_stb, rd_stb, cp_read, cp_write, ext_rd, ext_wr} = '0;
    {addr, wdata, ext_addr, ext_wdata} = '0;
    bad_count = 0; compares = 0; cyc = 0;
    void'($urandom(32'h5C46));
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    rd(3'h2, 8'h00, 8'h06);
    rd(3'h3, 8'h00, 8'hFF);
    rd(3'h4, 8'h00, 8'h03);
    idle(2); $display("test reset_state done");
    a0 = 8'($urandom); d0 = 8'($urandom);
    wr(3'h5, 8'h01); wr(3'h0, a0); wr(3'h1, d0); wr(3'h2, 8'h04);
    unlock; wr(3'h2, 8'h06);
    rd(3'h2, 8'h02, 8'h02);
    wr(3'h0, ~a0); rd(3'h0, a0, 8'hFF);
    wait_done; chk("irq", 8'h01, {7'h00, irq}, 8'h01);
    rd(3'h2, 8'h04, 8'h06);
    rd(3'h4, 8'h01, 8'h01);
    wr(3'h2, 8'h05); idle(1); rd(3'h1, d0, 8'hFF);
    idle(2); $display("test keyed_write done");
    // enable with start, reversed keys, broken keys, program space
    for (i = 0; i < 4; i++) begin
      wr(3'h2, i == 0 ? 8'h00 : (i == 3 ? 8'h84 : 8'h04));
      if (i == 1) begin
        wr(3'h3, 8'hAA); wr(3'h3, 8'h55);
      end else if (i == 2) begin
        wr(3'h3, 8'h55); wr(3'h1, 8'h00); wr(3'h3, 8'hAA);
      end else unlock;
      wr(3'h2, i == 3 ? 8'h86 : 8'h06);
      rd(3'h2, 8'h00, 8'h02);
      idle(12); chk("wake", 8'h00, {7'h00, wake}, 8'h01);
    end
    $display("test refused_start done");
    wr(3'h2, 8'h04); idle(2);
    // every protect setting against the external programmer
    for (i = 0; i < 4; i++) begin
      {cp_write, cp_read} <= i[1:0];
      @(posedge clk);
      if (i == 0) ext_q.push_back(d0);
      ext(1'h1, 1'h0); ext(1'h0, i != 0);
      rd(3'h4, i != 0 ? 8'h02 : 8'h00, 8'h02);
      idle(1);
    end
    wr(3'h2, 8'h05); idle(1); rd(3'h1, d0, 8'hFF);
    wr(3'h5, 8'h00); idle(3);
    $display("test code_protect done");
    // refresh walk: read bytes 0 to 3, rewrite each with the key sequence
    wr(3'h2, 8'h04);
    for (i = 0; i < 4; i++) begin
      wr(3'h0, i[7:0]); wr(3'h2, 8'h05); idle(1);
      unlock; wr(3'h2, 8'h06); wait_done;
      rd(3'h4, 8'h01, 8'h01); idle(1);
    end
    wr(3'h2, 8'h00);
    rd(3'h2, 8'h00, 8'h06); idle(2);
    $display("test refresh done");
    report_and_stop;
  end
endmodule // tb_data_eeprom_access_control
bind nvac_ctrl nvac_asserts u_chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .cp_read(cp_read), .cp_write(cp_write), .ext_rd(ext_rd),
  .ext_wr(ext_wr), .ext_refused(ext_refused), .wake(wake), .irq(irq));
